/* File: rtl/hsc_dev.sv */
/*
 * hsc_dev: serial host port clock master. Generates the bus clock from a
 * six-bit divider and optional divide-by-eight prescaler, frames bytes
 * with start and stop and keeps standard-mode bus timing.
 * Assumes an open-drain carrier with pull-ups and a 40 MHz core clock.
 */
`timescale 1ns/100ps
`default_nettype none
module hsc_dev (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	// clock settings
	input wire logic [hsc_pkg::DIV_W-1:0] DIVIDER_MODULUS_FIELD,
	input wire logic PRESCALER_BYPASS_BIT,
	input wire logic STD_MODE,
	// byte request
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic [7:0] REQ_DATA,
	input wire logic REQ_LAST,
	output logic ACK_SEEN,
	output logic BUSY,
	// link
	hsc_if.dev LINK
);
	import hsc_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_START, S_LOW, S_HIGH, S_STOP,
		S_BUF} hsc_state_t;
	// ==========================================================
	// clock tick generator
	hsc_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q;
	logic [8:0] tmin_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic last_q, scl_q, sda_q, ack_q;
	wire logic [CNT_W-1:0] reload =
		hsc_half_reload(DIVIDER_MODULUS_FIELD, PRESCALER_BYPASS_BIT);
	wire logic half_done = (cnt_q == '0);
	wire logic tmin_done = ~STD_MODE | (tmin_q == '0);
	wire logic step = half_done & tmin_done;
	wire logic ack_bit = (bit_q == 4'h8);
	// bit count nine marks the low phase that leads into stop
	wire logic stop_bit = (bit_q == 4'h9);
	// next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			S_IDLE: if (REQ_VALID) st_d = S_START;
			S_START: if (step) st_d = S_LOW;
			S_LOW: if (step) st_d = stop_bit ? S_STOP : S_HIGH;
			// every high phase ends low; stop needs sda low under it
			S_HIGH: if (step && LINK.scl) st_d = S_LOW;
			S_STOP: if (step) st_d = S_BUF;
			S_BUF: if (step) st_d = S_IDLE;
		endcase
	end
	// wait floor per phase in standard mode
	wire logic [8:0] tmin_n =
		(st_d == S_START) ? W_HD_STA :
		(st_d == S_LOW) ? W_LOW :
		(st_d == S_HIGH) ? W_HIGH :
		(st_d == S_STOP) ? W_SU_STO :
		(st_d == S_BUF) ? W_BUF : 9'h000;
	wire logic take = (st_q == S_IDLE && REQ_VALID) ||
		(st_q == S_HIGH && step && LINK.scl && ack_bit && !last_q &&
		REQ_VALID);
	assign REQ_READY = take;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q <= S_IDLE;
			cnt_q <= '0;
			tmin_q <= '0;
		end else begin
			st_q <= st_d;
			// hold the count while a far end stretches the clock
			if (st_d != st_q) cnt_q <= reload;
			else if (!half_done && !(st_q == S_HIGH && !LINK.scl))
				cnt_q <= cnt_q - 10'h001;
			if (st_d != st_q) tmin_q <= tmin_n;
			else if (tmin_q != '0) tmin_q <= tmin_q - 9'h001;
		end
	end
	// ==========================================================
	// byte shifter and line drivers
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			bit_q <= '0;
			sh_q <= '0;
			last_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			ack_q <= 1'b0;
		end else begin
			if (take) begin
				sh_q <= REQ_DATA;
				last_q <= REQ_LAST;
				bit_q <= 4'h0;
			end
			unique case (st_d)
				S_IDLE, S_BUF: begin
					scl_q <= 1'b1;
					sda_q <= 1'b1;
				end
				S_START: scl_q <= 1'b1;
				S_LOW: scl_q <= 1'b0;
				S_HIGH: scl_q <= 1'b1;
				S_STOP: scl_q <= 1'b1;
			endcase
			if (st_q == S_START && st_d == S_LOW) sda_q <= 1'b0;
			// data set while clock is low, long before rising
			if (st_q == S_LOW && st_d == S_LOW && cnt_q == reload)
				sda_q <= stop_bit ? 1'b0 : ack_bit ? 1'b1 : sh_q[7];
			if (st_q == S_LOW && st_d == S_HIGH && bit_q != 4'h8)
				sh_q <= {sh_q[6:0], 1'b0};
			if (st_q == S_HIGH && st_d == S_LOW && !take)
				bit_q <= bit_q + 4'h1;
			if (st_q == S_HIGH && st_d != S_HIGH && ack_bit)
				ack_q <= ~LINK.sda;
			if (st_q == S_STOP && st_d == S_BUF) sda_q <= 1'b1;
			// start: sda falls while the clock is still high
			if (st_d == S_START) sda_q <= 1'b0;
		end
	end
	// ==========================================================
	// outputs
	assign LINK.scl_o_dev = 1'b0;
	assign LINK.scl_oe_dev = ~scl_q;
	assign LINK.sda_o_dev = 1'b0;
	assign LINK.sda_oe_dev = ~sda_q;
	assign ACK_SEEN = ack_q;
	assign BUSY = (st_q != S_IDLE);
endmodule : hsc_dev
`default_nettype wire

/* File: rtl/hsc_far.sv */
/*
 * hsc_far: slave end of the link. Detects start and stop, shifts in
 * bytes, acknowledges each one and presents it to the user.
 * Assumes link lines synchronous to CLK_SYS.
 */
`timescale 1ns/100ps
`default_nettype none
module hsc_far (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	// received bytes
	output logic RX_VALID,
	output logic [7:0] RX_DATA,
	output logic IN_FRAME,
	// link
	hsc_if.far LINK
);
	import hsc_pkg::*;
	// ==========================================================
	// edge and condition detect
	logic scl_q, sda_q, frame_q, ack_q, vld_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, rx_q;
	wire logic rise = LINK.scl & ~scl_q;
	wire logic fall = ~LINK.scl & scl_q;
	wire logic start = LINK.scl & scl_q & sda_q & ~LINK.sda;
	wire logic stop = LINK.scl & scl_q & ~sda_q & LINK.sda;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			frame_q <= 1'b0;
			bit_q <= '0;
			sh_q <= '0;
			rx_q <= '0;
			ack_q <= 1'b0;
			vld_q <= 1'b0;
		end else begin
			scl_q <= LINK.scl;
			sda_q <= LINK.sda;
			vld_q <= 1'b0;
			if (start) begin
				frame_q <= 1'b1;
				bit_q <= '0;
			end else if (stop) begin
				frame_q <= 1'b0;
				ack_q <= 1'b0;
			end else if (frame_q && rise && bit_q != 4'h8) begin
				sh_q <= {sh_q[6:0], LINK.sda};
				bit_q <= bit_q + 4'h1;
			end else if (frame_q && fall) begin
				// ack drives right after the fall, well within the limit
				if (bit_q == 4'h8 && !ack_q) begin
					ack_q <= 1'b1;
					rx_q <= sh_q;
					vld_q <= 1'b1;
				end else if (ack_q) begin
					ack_q <= 1'b0;
					bit_q <= '0;
				end
			end
		end
	end
	assign LINK.scl_o_far = 1'b1;
	assign LINK.scl_oe_far = 1'b0;
	assign LINK.sda_o_far = 1'b0;
	assign LINK.sda_oe_far = ack_q;
	assign RX_VALID = vld_q;
	assign RX_DATA = rx_q;
	assign IN_FRAME = frame_q;
endmodule : hsc_far
`default_nettype wire

/* File: shared/hsc_if.sv */
/*
 * hsc_if: open-drain clock and data wires between the two ends.
 * Assumes both ends share CLK_SYS; pull-ups are modelled here.
 */
`timescale 1ns/100ps
`default_nettype none
interface hsc_if;
	logic scl_o_dev, scl_oe_dev, sda_o_dev, sda_oe_dev;
	logic scl_o_far, scl_oe_far, sda_o_far, sda_oe_far;
	logic scl, sda;
	// ==========================================================
	// wired-and with pull-up
	assign scl = ~((scl_oe_dev & ~scl_o_dev) | (scl_oe_far & ~scl_o_far));
	assign sda = ~((sda_oe_dev & ~sda_o_dev) | (sda_oe_far & ~sda_o_far));
	modport dev (input scl, input sda, output scl_o_dev, output scl_oe_dev,
		output sda_o_dev, output sda_oe_dev);
	modport far (input scl, input sda, output scl_o_far, output scl_oe_far,
		output sda_o_far, output sda_oe_far);
endinterface : hsc_if
`default_nettype wire

/* File: shared/hsc_pkg.sv */
/*
 * hsc_pkg: constants shared by both ends of the two-wire serial clock link.
 * Assumes a 40 MHz core clock (25 ns period) on both ends.
 */
`default_nettype none
package hsc_pkg;
	// ==========================================================
	// clock divider
	localparam int DIV_W = 6;
	localparam logic [5:0] DIV_MAX = 6'h3F;
	localparam int PRE_RATIO = 8;
	localparam int PRE_W = 3;
	localparam int CNT_W = 10;
	localparam logic [5:0] DIV_RST = 6'h3F;
	localparam logic BYP_RST = 1'b0;
	// ==========================================================
	// timing, standard mode
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_CYCLE_NS = 10000;
	localparam int T_LOW_NS = 4700;
	localparam int T_HIGH_NS = 4000;
	localparam int T_HD_STA_NS = 4000;
	localparam int T_SU_STA_NS = 4700;
	localparam int T_SU_STO_NS = 4000;
	localparam int T_BUF_NS = 4700;
	localparam int T_SU_DAT_NS = 250;
	localparam int T_VD_DAT_NS = 3400;
	localparam int HZ_STD_KHZ = 100;
	localparam int HZ_FAST_KHZ = 1000;
	// least times round up
	localparam int T_LOW_CYC = (T_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_HIGH_CYC = (T_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_HD_STA_CYC = (T_HD_STA_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_SU_STA_CYC = (T_SU_STA_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_SU_STO_CYC = (T_SU_STO_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_BUF_CYC = (T_BUF_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int T_SU_DAT_CYC = (T_SU_DAT_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	// longest time rounds down
	localparam int T_VD_DAT_CYC = (T_VD_DAT_NS * 1000) / CLK_PERIOD_PS;
	localparam int T_WAIT_W = 9;
	localparam logic [8:0] W_LOW = 9'(T_LOW_CYC);
	localparam logic [8:0] W_HIGH = 9'(T_HIGH_CYC);
	localparam logic [8:0] W_HD_STA = 9'(T_HD_STA_CYC);
	localparam logic [8:0] W_SU_STA = 9'(T_SU_STA_CYC);
	localparam logic [8:0] W_SU_STO = 9'(T_SU_STO_CYC);
	localparam logic [8:0] W_BUF = 9'(T_BUF_CYC);
	localparam logic [8:0] W_SU_DAT = 9'(T_SU_DAT_CYC);
	localparam logic [8:0] W_VD_DAT = 9'(T_VD_DAT_CYC);

	// half period in core cycles minus one: (div+1)*(byp?1:8)-1
	function automatic logic [CNT_W-1:0] hsc_half_reload(
		input logic [DIV_W-1:0] div, input logic byp);
		logic [CNT_W-1:0] n;
		n = {4'h0, div} + 10'h001;
		hsc_half_reload = (byp ? n : {n[CNT_W-4:0], 3'h0}) - 10'h001;
	endfunction : hsc_half_reload
endpackage : hsc_pkg
`default_nettype wire

/* File: sim/hsc_properties.sv */
/* hsc_properties: timing checks on the shared link wires.
   Assumes one core clock and the package's standard-mode floors. */
`timescale 1ns/100ps
`default_nettype none
module hsc_properties (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	// settings
	input wire logic [hsc_pkg::DIV_W-1:0] DIVIDER_MODULUS_FIELD,
	input wire logic PRESCALER_BYPASS_BIT,
	input wire logic STD_MODE,
	// link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe_far,
	input wire logic sda_oe_far
);
	import hsc_pkg::*;
	// ==========================================================
	// phase length counters
	logic scl_q, sda_q, sc_up, sc_dn, sd_up, sd_dn;
	logic [9:0] c_scl_q, c_sda_q, half;
	assign half = ({4'h0, DIVIDER_MODULUS_FIELD} + 10'h001)
		* (PRESCALER_BYPASS_BIT ? 10'h001 : 10'h008);
	assign sc_up = scl & ~scl_q;
	assign sc_dn = ~scl & scl_q;
	assign sd_up = sda & ~sda_q;
	assign sd_dn = ~sda & sda_q;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			c_scl_q <= 10'h3FF;
			c_sda_q <= 10'h3FF;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			c_scl_q <= (scl ^ scl_q) ? 10'h001 : c_scl_q + 10'(~&c_scl_q);
			c_sda_q <= (sda ^ sda_q) ? 10'h001 : c_sda_q + 10'(~&c_sda_q);
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	a_low_exact: assert property (sc_up && !STD_MODE |-> c_scl_q == half)
		else $error("low phase not half period");
	a_low_floor: assert property (sc_up && STD_MODE |->
		c_scl_q >= 10'(T_LOW_CYC) && c_scl_q >= half) else $error("low short");
	a_high_floor: assert property (sc_dn && STD_MODE |->
		c_scl_q >= 10'(T_HIGH_CYC)) else $error("high short");
	a_start_hold: assert property (sc_dn && STD_MODE && c_sda_q < c_scl_q
		|-> c_sda_q >= 10'(T_HD_STA_CYC)) else $error("start hold short");
	a_stop_setup: assert property (sd_up && scl && STD_MODE |->
		c_scl_q >= 10'(T_SU_STO_CYC)) else $error("stop setup short");
	a_bus_free: assert property (sd_dn && scl && STD_MODE |->
		c_sda_q >= 10'(T_BUF_CYC)) else $error("bus free short");
	a_data_setup: assert property (sc_up && STD_MODE |->
		c_sda_q >= 10'(T_SU_DAT_CYC)) else $error("data setup short");
	a_ack_edge: assert property ($changed(sda_oe_far) |-> !scl)
		else $error("far data moved with clock high");
	a_no_stretch: assert property (scl_oe_far == 1'b0)
		else $error("far end held clock");
	c_start: cover property (sd_dn && scl);
	c_stop: cover property (sd_up && scl);
	c_ack: cover property ($rose(sda_oe_far));
endmodule : hsc_properties
`default_nettype wire

/* File: sim/tb_host_serial_i2c_clock_timing.sv */
/* tb_host_serial_i2c_clock_timing: both link ends back to back.
   Assumes a 40 MHz CLK_SYS and random bytes. */
`timescale 1ns/100ps
`default_nettype none
module tb_host_serial_i2c_clock_timing;
	import hsc_pkg::*;
	logic CLK_SYS = 1'b0, ARST_N = 1'b0, byp = 1'b1, std = 1'b0;
	logic [DIV_W-1:0] div = 6'h02;
	logic v = 1'b0, last = 1'b0, ack_exp = 1'b0;
	logic [7:0] d = 8'h00, rx_data, rx_q[$];
	logic rdy, ack, busy, rx_v, in_fr;
	int errors = 0, n_tests = 0, cyc = 0, per = 0;
	real t_prev = 0.0;
	hsc_if u_hsc_if ();
	hsc_dev u_hsc_dev (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
		.DIVIDER_MODULUS_FIELD(div), .PRESCALER_BYPASS_BIT(byp),
		.STD_MODE(std), .REQ_VALID(v), .REQ_READY(rdy), .REQ_DATA(d),
		.REQ_LAST(last), .ACK_SEEN(ack), .BUSY(busy), .LINK(u_hsc_if.dev));
	hsc_far u_hsc_far (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .RX_VALID(rx_v),
		.RX_DATA(rx_data), .IN_FRAME(in_fr), .LINK(u_hsc_if.far));
	hsc_properties u_hsc_properties (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
		.DIVIDER_MODULUS_FIELD(div), .PRESCALER_BYPASS_BIT(byp),
		.STD_MODE(std), .scl(u_hsc_if.scl), .sda(u_hsc_if.sda),
		.scl_oe_far(u_hsc_if.scl_oe_far), .sda_oe_far(u_hsc_if.sda_oe_far));
	// ==========================================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// ==========================================================
	// byte and frame drivers
	task automatic send(input logic [7:0] b, input logic l, input logic f);
		v = 1'b1;
		d = b;
		last = l;
		rx_q.push_back(b);
		#1;
		while (rdy !== 1'b1) begin
			@(negedge CLK_SYS);
			#1;
		end
		if (f) begin
			check(32'(busy), 32'(0));
			check(32'(ack), 32'(ack_exp));
			ack_exp = 1'b1;
		end
		@(negedge CLK_SYS);
	endtask : send
	task automatic run(input logic [5:0] dv, input logic bp, input logic sm);
		int n;
		div = dv;
		byp = bp;
		std = sm;
		per = 50 * (int'(dv) + 1) * (bp ? 1 : 8);
		repeat (200) @(negedge CLK_SYS);
		// second frame is requested while the first one's last byte is still being sent
		for (int f = 0; f < 2; f++) begin
			n = $urandom_range(2, 1);
			for (int i = 0; i < n; i++) send(8'($urandom), i == n - 1, i == 0);
		end
		v = 1'b0;
		#1;
		while (busy !== 1'b0) @(negedge CLK_SYS);
	endtask : run
	// ==========================================================
	// clock, monitors, watchdog
	always #12.5 CLK_SYS = ~CLK_SYS;
	always @(negedge CLK_SYS) begin
		if (rx_v === 1'b1) begin
			check(32'(rx_data), 32'(rx_q.pop_front()));
			check(32'(in_fr), 32'(1));
		end
	end
	always @(negedge u_hsc_if.scl) begin
		if (t_prev > 0.0 && !std) check(32'(int'($realtime - t_prev)), 32'(per));
		t_prev = $realtime;
	end
	always @(negedge busy) t_prev = 0.0;
	always @(negedge CLK_SYS) begin
		cyc++;
		if (cyc > 95000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		void'($urandom(37563));
		repeat (2) @(negedge CLK_SYS);
		ARST_N = 1'b1;
		run(6'h02, 1'b1, 1'b0);
		run(6'h3F, 1'b0, 1'b0);
		run(6'h05, 1'b0, 1'b1);
		run(6'h3F, 1'b1, 1'b1);
		for (int k = 0; k < 3; k++) run(6'($urandom_range(63, 2)), 1'b1, 1'b0);
		stop_test();
	end
endmodule : tb_host_serial_i2c_clock_timing
`default_nettype wire
